/* pdc_pkg.sv */
`default_nettype none

// Shared constants of the port direction control block.
package pdc_pkg;

  // Byte address width of the register slave.
  localparam int AW = 22;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [19:0] IDX_P0 = 20'hFFF20;
  localparam logic [19:0] IDX_P1 = 20'hFFF21;
  localparam logic [19:0] IDX_P2 = 20'hFFF22;
  localparam logic [19:0] IDX_P4 = 20'hFFF24;
  localparam logic [19:0] IDX_P5 = 20'hFFF25;
  localparam logic [19:0] IDX_P6 = 20'hFFF26;
  localparam logic [19:0] IDX_P7 = 20'hFFF27;
  localparam logic [19:0] IDX_P14 = 20'hFFF2E;
  localparam logic [19:0] IDX_P15 = 20'hFFF2F;
  // Port 13 control and status words.
  localparam logic [19:0] IDX_CTRL = 20'hFFF30;
  localparam logic [19:0] IDX_STAT = 20'hFFF31;

  // Every direction register comes out of reset as all ones.
  localparam logic [7:0] DIR_RST = 8'hFF;
  // Slot code returned for an address that holds no direction register.
  localparam logic [3:0] SLOT_NONE = 4'hF;

  // Writable direction bits per slot, slot 0 on the right; a zero is a fixed one.
  // Slot order: port 0, 1, 2, 4, 5, 6, 7, 14, 15.
  localparam logic [8:0][7:0] WMASK_64 = {8'h1F, 8'h03, 8'hFF, 8'h0F, 8'h00,
                                          8'h0F, 8'hFF, 8'h5F, 8'h7F};
  localparam logic [8:0][7:0] WMASK_80 = {8'h1F, 8'h03, 8'hFF, 8'h0F, 8'h03,
                                          8'h0F, 8'hFF, 8'h7F, 8'h7F};

  // Field positions of the port 13 control word.
  localparam int CTL_OUT = 0;
  localparam int CTL_IRQ_EN = 1;
  localparam int CTL_EDGE = 2;
  // Field positions of the port 13 status word.
  localparam int STA_LEVEL = 0;
  localparam int STA_PKG80 = 1;
  localparam int STA_SEEN = 2;

  // Valid edge of the external interrupt zero input.
  typedef enum logic [1:0] {
    EDGE_FALL = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_BOTH = 2'h2,
    EDGE_NONE = 2'h3
  } pdc_edge_t;

  // Bus response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

/* pdc_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for levels that arrive from outside the clock domain.
module pdc_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  // Both stages; the first is read by the second only.
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pdc_sync_st_t;

  pdc_sync_st_t st_reg;
  pdc_sync_st_t st_next;

  // Shift the raw level one stage per enabled clock.
  always_comb begin
    st_next = st_reg;
    st_next.s1 = i_d;
    st_next.s2 = st_reg.s1;
  end

  // State freezes while the clock enable is low.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_q = st_reg.s2;

endmodule

`default_nettype wire

/* pdc_top.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - 80-pin has port 5 with two bits.
// - Direction registers reset all ones, 8-bit, RW except the bits fixed at one.
// - Port 13 bit 0 is output only.
// - Port 13 bit 7 is readable input only.
// - Control mode routes it to interrupt zero.
// - Valid edge: rising, falling or both.
module pdc_top (
  input  wire logic                   I_MCLK,
  input  wire logic                   I_RST_N,
  input  wire logic                   I_CE,
  input  wire logic                   I_PKG80,
  input  wire logic                   I_PORT13_BIT7_IN,
  input  wire logic [71:0]            I_PORT_LATCH,
  input  wire logic                   I_AWVALID,
  input  wire logic [pdc_pkg::AW-1:0] I_AWADDR,
  output logic                        O_AWREADY,
  input  wire logic                   I_WVALID,
  input  wire logic [31:0]            I_WDATA,
  input  wire logic [3:0]             I_WSTRB,
  output logic                        O_WREADY,
  output logic                        O_BVALID,
  output logic      [1:0]             O_BRESP,
  input  wire logic                   I_BREADY,
  input  wire logic                   I_ARVALID,
  input  wire logic [pdc_pkg::AW-1:0] I_ARADDR,
  output logic                        O_ARREADY,
  output logic                        O_RVALID,
  output logic      [31:0]            O_RDATA,
  output logic      [1:0]             O_RRESP,
  input  wire logic                   I_RREADY,
  output logic      [71:0]            O_PIN_OE_N,
  output logic      [71:0]            O_PIN_OUT,
  output logic                        O_PORT13_BIT0_OUT,
  output logic                        O_EXT_IRQ_ZERO
);

  // The whole state of the block, apart from the synchroniser stages, in one word.
  typedef struct packed {
    logic [8:0][7:0]   dir;      // Direction registers, one slot per port.
    logic [71:0]       pout;     // Registered output latch values.
    logic              pkg80;    // Package variant caught from the strap.
    logic              lvl_d;    // Previous synchronised port 13 bit 7 level.
    logic              out13;    // Port 13 bit 0 output value.
    logic              irq_en;   // Control mode of port 13 bit 7.
    pdc_pkg::pdc_edge_t edge_sel; // Valid edge selection.
    logic              seen;     // Sticky record of a valid edge.
    logic              irq;      // One-cycle interrupt request.
    logic              aw_got;   // Write address held.
    logic              w_got;    // Write data held.
    logic [19:0]       widx;     // Held write index.
    logic [7:0]        wdata;    // Held write data, low byte.
    logic              wstrb0;   // Held strobe of the low byte lane.
    logic              awready;  // Write address channel ready.
    logic              wready;   // Write data channel ready.
    logic              bvalid;   // Write response pending.
    logic [1:0]        bresp;    // Write response code.
    logic              arready;  // Read address channel ready.
    logic              rvalid;   // Read data pending.
    logic [31:0]       rdata;    // Read data word.
    logic [1:0]        rresp;    // Read response code.
  } pdc_state_t;

  pdc_state_t st_reg;
  pdc_state_t st_next;

  // Synchronised strap and port 13 bit 7 level.
  logic [1:0] sync_q;
  logic       lvl_s;
  logic       pkg_s;

  // Strap and pin level cross in through two flip-flops.
  pdc_sync #(
    .W (2)
  ) u_sync (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RST_N),
    .i_ce    (I_CE),
    .i_d     ({I_PKG80, I_PORT13_BIT7_IN}),
    .o_q     (sync_q)
  );

  assign lvl_s = sync_q[0];
  assign pkg_s = sync_q[1];

  // Writable bits of one slot for the given package variant.
  function automatic logic [7:0] wmask(input logic [3:0] k, input logic p80);
    logic [7:0] m;
    m = p80 ? pdc_pkg::WMASK_80[k] : pdc_pkg::WMASK_64[k];
    return m;
  endfunction

  // Slot of a direction register index; port 5 exists only on 80 pins.
  function automatic logic [3:0] slot_of(input logic [19:0] idx, input logic p80);
    logic [3:0] s;
    s = pdc_pkg::SLOT_NONE;
    case (idx)
      pdc_pkg::IDX_P0:  s = 4'h0;
      pdc_pkg::IDX_P1:  s = 4'h1;
      pdc_pkg::IDX_P2:  s = 4'h2;
      pdc_pkg::IDX_P4:  s = 4'h3;
      pdc_pkg::IDX_P5:  s = p80 ? 4'h4 : pdc_pkg::SLOT_NONE;
      pdc_pkg::IDX_P6:  s = 4'h5;
      pdc_pkg::IDX_P7:  s = 4'h6;
      pdc_pkg::IDX_P14: s = 4'h7;
      pdc_pkg::IDX_P15: s = 4'h8;
      default:          s = pdc_pkg::SLOT_NONE;
    endcase
    return s;
  endfunction

  // Edge detector terms on the synchronised pin level.
  logic rise;
  logic fall;
  logic hit;
  // Write path decode.
  logic       do_wr;
  logic [3:0] wslot;
  // Read path decode.
  logic       ar_hs;
  logic [19:0] ridx;
  logic [3:0] rslot;

  // Next-state logic: bus slave, registers and the interrupt edge.
  always_comb begin
    st_next = st_reg;
    rise = lvl_s & ~st_reg.lvl_d;
    fall = ~lvl_s & st_reg.lvl_d;
    // The edge only counts in control mode, and only the chosen kind.
    hit = 1'b0;
    if (st_reg.irq_en) begin
      unique case (st_reg.edge_sel)
        pdc_pkg::EDGE_RISE: hit = rise;
        pdc_pkg::EDGE_FALL: hit = fall;
        pdc_pkg::EDGE_BOTH: hit = rise | fall;
        pdc_pkg::EDGE_NONE: hit = 1'b0;
      endcase
    end
    st_next.irq = hit;
    st_next.lvl_d = lvl_s;
    st_next.pkg80 = pkg_s;
    // A zero direction bit lets the pin drive the latch value.
    st_next.pout = I_PORT_LATCH;

    // Accept address and data in either order and hold them.
    if (I_AWVALID && st_reg.awready) begin
      st_next.aw_got = 1'b1;
      st_next.widx = I_AWADDR[pdc_pkg::AW-1:2];
    end
    if (I_WVALID && st_reg.wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = I_WDATA[7:0];
      st_next.wstrb0 = I_WSTRB[0];
    end
    if (st_reg.bvalid && I_BREADY) begin
      st_next.bvalid = 1'b0;
    end

    // Both halves present and no response waiting: perform the write.
    do_wr = st_next.aw_got && st_next.w_got && !st_reg.bvalid;
    wslot = slot_of(st_next.widx, st_reg.pkg80);
    if (do_wr) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = pdc_pkg::RESP_OKAY;
      if (wslot != pdc_pkg::SLOT_NONE) begin
        // Fixed bits are kept below; only the writable ones take data.
        if (st_next.wstrb0) begin
          st_next.dir[wslot] = st_next.wdata;
        end
      end else if (st_next.widx == pdc_pkg::IDX_CTRL) begin
        if (st_next.wstrb0) begin
          st_next.out13 = st_next.wdata[pdc_pkg::CTL_OUT];
          st_next.irq_en = st_next.wdata[pdc_pkg::CTL_IRQ_EN];
          st_next.edge_sel = pdc_pkg::pdc_edge_t'(st_next.wdata[pdc_pkg::CTL_EDGE +: 2]);
        end
      end else if (st_next.widx == pdc_pkg::IDX_STAT) begin
        // Writing one to the sticky bit clears it.
        if (st_next.wstrb0 && st_next.wdata[pdc_pkg::STA_SEEN]) begin
          st_next.seen = 1'b0;
        end
      end else begin
        // Unmapped words answer with a slave error and change nothing.
        st_next.bresp = pdc_pkg::RESP_SLVERR;
      end
    end
    // A fresh edge wins over a clear in the same cycle.
    if (hit) begin
      st_next.seen = 1'b1;
    end

    // Bits without a pin or with a fixed value always read as one.
    for (int k = 0; k < 9; k++) begin
      st_next.dir[k] = st_next.dir[k] | ~wmask(4'(k), st_next.pkg80);
    end

    // Read channel: one read under way, answered the next cycle.
    if (st_reg.rvalid && I_RREADY) begin
      st_next.rvalid = 1'b0;
    end
    ar_hs = I_ARVALID && st_reg.arready;
    ridx = I_ARADDR[pdc_pkg::AW-1:2];
    rslot = slot_of(ridx, st_reg.pkg80);
    if (ar_hs) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = pdc_pkg::RESP_OKAY;
      st_next.rdata = 32'h0000_0000;
      if (rslot != pdc_pkg::SLOT_NONE) begin
        st_next.rdata[7:0] = st_reg.dir[rslot];
      end else if (ridx == pdc_pkg::IDX_CTRL) begin
        st_next.rdata[pdc_pkg::CTL_OUT] = st_reg.out13;
        st_next.rdata[pdc_pkg::CTL_IRQ_EN] = st_reg.irq_en;
        st_next.rdata[pdc_pkg::CTL_EDGE +: 2] = st_reg.edge_sel;
      end else if (ridx == pdc_pkg::IDX_STAT) begin
        st_next.rdata[pdc_pkg::STA_LEVEL] = lvl_s;
        st_next.rdata[pdc_pkg::STA_PKG80] = st_reg.pkg80;
        st_next.rdata[pdc_pkg::STA_SEEN] = st_reg.seen;
      end else begin
        st_next.rresp = pdc_pkg::RESP_SLVERR;
      end
    end

    // Ready flags are registered so every bus output leaves a flop.
    st_next.awready = !st_next.aw_got && !st_next.bvalid;
    st_next.wready = !st_next.w_got && !st_next.bvalid;
    st_next.arready = !st_next.rvalid;
  end

  // State register; a low clock enable freezes everything.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_reg <= '0;
      st_reg.dir <= {9{pdc_pkg::DIR_RST}};
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
    end else if (I_CE) begin
      st_reg <= st_next;
    end
  end

  // Every output is a flip-flop of the state word.
  assign O_AWREADY = st_reg.awready;
  assign O_WREADY = st_reg.wready;
  assign O_BVALID = st_reg.bvalid;
  assign O_BRESP = st_reg.bresp;
  assign O_ARREADY = st_reg.arready;
  assign O_RVALID = st_reg.rvalid;
  assign O_RDATA = st_reg.rdata;
  assign O_RRESP = st_reg.rresp;
  // Output enable is low while driving, so it equals the direction bit.
  assign O_PIN_OE_N = st_reg.dir;
  assign O_PIN_OUT = st_reg.pout;
  // Port 13 bit 0 has no direction control and always drives.
  assign O_PORT13_BIT0_OUT = st_reg.out13;
  assign O_EXT_IRQ_ZERO = st_reg.irq;

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_N);

  // Enabled write of port 0 direction, address and data together.
  sequence s_wr_p0;
    I_CE && I_AWVALID && O_AWREADY && I_WVALID && O_WREADY &&
      I_AWADDR[pdc_pkg::AW-1:2] == pdc_pkg::IDX_P0 && I_WSTRB[0];
  endsequence

  // Enabled write of the port 13 control word.
  sequence s_wr_ctrl;
    I_CE && I_AWVALID && O_AWREADY && I_WVALID && O_WREADY &&
      I_AWADDR[pdc_pkg::AW-1:2] == pdc_pkg::IDX_CTRL && I_WSTRB[0];
  endsequence

  // Enabled read request taken.
  sequence s_rd;
    I_CE && I_ARVALID && O_ARREADY;
  endsequence

  property p_fix_ones;
    st_reg.dir[0][7] && (&st_reg.dir[3][7:4]);
  endproperty
  a_fix_ones: assert property (p_fix_ones)
    else $error("fixed direction bits lost their one");

  property p_port5;
    st_reg.pkg80 ? (&st_reg.dir[4][7:2]) : (st_reg.dir[4] == 8'hFF);
  endproperty
  a_port5: assert property (p_port5)
    else $error("port 5 direction has wrong fixed bits");

  property p_rd_lat;
    s_rd |=> O_RVALID;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer not one cycle after request");

  property p_rd_p0;
    s_rd and I_ARADDR[pdc_pkg::AW-1:2] == pdc_pkg::IDX_P0
      |=> O_RDATA == {24'h00_0000, $past(st_reg.dir[0])};
  endproperty
  a_rd_p0: assert property (p_rd_p0)
    else $error("port 0 direction read back wrong");

  property p_wr_oe;
    s_wr_p0 |=> O_BVALID && O_PIN_OE_N[6:0] == $past(I_WDATA[6:0]);
  endproperty
  a_wr_oe: assert property (p_wr_oe)
    else $error("direction write did not steer the enables");

  property p_out13;
    s_wr_ctrl |=> O_PORT13_BIT0_OUT == $past(I_WDATA[0]);
  endproperty
  a_out13: assert property (p_out13)
    else $error("port 13 bit 0 output not updated");

  property p_level;
    s_rd and I_ARADDR[pdc_pkg::AW-1:2] == pdc_pkg::IDX_STAT
      |=> O_RDATA[0] == $past(lvl_s);
  endproperty
  a_level: assert property (p_level)
    else $error("port 13 bit 7 level read back wrong");

  property p_irq_off;
    I_CE && !st_reg.irq_en |=> !O_EXT_IRQ_ZERO;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt request outside control mode");

  property p_irq_rise;
    I_CE && st_reg.irq_en && st_reg.edge_sel == pdc_pkg::EDGE_RISE && rise
      |=> O_EXT_IRQ_ZERO ##1 (!O_EXT_IRQ_ZERO || !$stable(lvl_s) || !I_CE);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("rising edge request missing");

  property p_irq_fall;
    I_CE && st_reg.irq_en && st_reg.edge_sel == pdc_pkg::EDGE_FALL && rise
      |=> !O_EXT_IRQ_ZERO;
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("rising edge taken in falling mode");

endmodule

`default_nettype wire

/* pdc_pins.sv */
`timescale 1ns/1ps
`default_nettype none

// Behavioural model of the package pins around the direction block.
module pdc_pins (
  input  wire logic [71:0] i_oe_n,
  input  wire logic [71:0] i_out,
  input  wire logic        i_lvl,
  output logic             o_bit7_in,
  output logic      [71:0] o_pad
);
  // A released pin floats up to its pull-up, so a stale driven value never shows.
  always_comb begin
    o_pad = i_oe_n | i_out;
  end

  // The port 13 input pin simply follows the level the bench asks for.
  always_comb begin
    o_bit7_in = i_lvl;
  end
endmodule

`default_nettype wire

/* tb_port_direction_control.sv */
`timescale 1ns/1ps
`default_nettype none

// Register-level bench for the port direction block.
module tb_port_direction_control;
  logic                   I_MCLK = 1'b0;
  logic                   I_RST_N = 1'b0;
  logic                   I_PKG80 = 1'b0;
  logic                   I_CE = 1'b1;
  logic                   pin_lvl = 1'b0;
  logic                   port13_bit7_in;
  logic [71:0]            I_PORT_LATCH = 72'h3C965AA50FF0C3691E;
  logic                   I_AWVALID = 1'b0;
  logic [pdc_pkg::AW-1:0] I_AWADDR = '0;
  logic                   I_WVALID = 1'b0;
  logic [31:0]            I_WDATA = '0;
  logic [3:0]             I_WSTRB = 4'h0;
  logic                   I_BREADY = 1'b0;
  logic                   I_ARVALID = 1'b0;
  logic [pdc_pkg::AW-1:0] I_ARADDR = '0;
  logic                   I_RREADY = 1'b0;
  logic                   O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic [1:0]             O_BRESP, O_RRESP;
  logic [31:0]            O_RDATA;
  logic [71:0]            O_PIN_OE_N, O_PIN_OUT, pads, eoe;
  logic                   O_PORT13_BIT0_OUT, O_EXT_IRQ_ZERO;
  int                     num_errors = 0;
  int                     checks_done = 0;
  int                     pulses = 0;
  // Register index of each slot, in the design's slot order.
  logic [19:0] idx [9] = '{pdc_pkg::IDX_P0, pdc_pkg::IDX_P1, pdc_pkg::IDX_P2,
                           pdc_pkg::IDX_P4, pdc_pkg::IDX_P5, pdc_pkg::IDX_P6,
                           pdc_pkg::IDX_P7, pdc_pkg::IDX_P14, pdc_pkg::IDX_P15};
  // Expected pulse counts for falling, rising, both and no edge.
  int exp_irq [4] = '{1, 1, 2, 0};

  // The clock runs at 250 MHz.
  always begin
    #2 I_MCLK = ~I_MCLK;
  end

  pdc_top u_dut (
    .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_CE(I_CE), .I_PKG80(I_PKG80),
    .I_PORT13_BIT7_IN(port13_bit7_in), .I_PORT_LATCH(I_PORT_LATCH),
    .I_AWVALID(I_AWVALID), .I_AWADDR(I_AWADDR), .O_AWREADY(O_AWREADY),
    .I_WVALID(I_WVALID), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB), .O_WREADY(O_WREADY),
    .O_BVALID(O_BVALID), .O_BRESP(O_BRESP), .I_BREADY(I_BREADY),
    .I_ARVALID(I_ARVALID), .I_ARADDR(I_ARADDR), .O_ARREADY(O_ARREADY),
    .O_RVALID(O_RVALID), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .I_RREADY(I_RREADY),
    .O_PIN_OE_N(O_PIN_OE_N), .O_PIN_OUT(O_PIN_OUT),
    .O_PORT13_BIT0_OUT(O_PORT13_BIT0_OUT), .O_EXT_IRQ_ZERO(O_EXT_IRQ_ZERO)
  );

  pdc_pins u_pins (
    .i_oe_n(O_PIN_OE_N), .i_out(O_PIN_OUT), .i_lvl(pin_lvl),
    .o_bit7_in(port13_bit7_in), .o_pad(pads)
  );

  // Interrupt pulses are one cycle wide, so they are counted at every rising clock edge.
  // An unknown level counts as a pulse, so it can never slip through quietly.
  always @(posedge I_MCLK) begin
    if (O_EXT_IRQ_ZERO !== 1'b0) pulses++;
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One write; bready is held until the response is seen.
  task automatic wr(input logic [19:0] ix, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic ok;
    ok = 1'b0;
    @(posedge I_MCLK);
    I_AWADDR <= {ix, 2'h0};
    I_WDATA <= {24'h0, d};
    I_WSTRB <= 4'h1;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    I_BREADY <= 1'b1;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge I_MCLK);
      if (I_AWVALID && O_AWREADY === 1'b1) I_AWVALID <= 1'b0;
      if (I_WVALID && O_WREADY === 1'b1) I_WVALID <= 1'b0;
      if (O_BVALID === 1'b1) begin
        ok = 1'b1;
        I_BREADY <= 1'b0;
        chk("bresp", er, O_BRESP);
      end
    end
    if (!ok) chk("bvalid", 1, 0);
  endtask

  // One read, compared with the expected data and response.
  task automatic rd(input logic [19:0] ix, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ok;
    ok = 1'b0;
    @(posedge I_MCLK);
    I_ARADDR <= {ix, 2'h0};
    I_ARVALID <= 1'b1;
    I_RREADY <= 1'b1;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge I_MCLK);
      if (I_ARVALID && O_ARREADY === 1'b1) I_ARVALID <= 1'b0;
      if (O_RVALID === 1'b1) begin
        ok = 1'b1;
        I_RREADY <= 1'b0;
        chk("rdata", ed, O_RDATA);
        chk("rresp", er, O_RRESP);
      end
    end
    if (!ok) chk("rvalid", 1, 0);
  endtask

  // Writes zero everywhere, then checks that only fixed-one bits stay set.
  task automatic sweep(input logic [8:0][7:0] m, input logic p80);
    for (int k = 0; k < 9; k++) begin
      wr(idx[k], 8'h00, (k == 4 && !p80) ? pdc_pkg::RESP_SLVERR : pdc_pkg::RESP_OKAY);
    end
    for (int k = 0; k < 9; k++) begin
      eoe[8*k +: 8] = ~m[k];
      if (k == 4 && !p80) rd(idx[k], 32'h0, pdc_pkg::RESP_SLVERR);
      else rd(idx[k], {24'h0, ~m[k]}, pdc_pkg::RESP_OKAY);
    end
    repeat (3) @(posedge I_MCLK);
    chk("oe_n", eoe, O_PIN_OE_N);
    chk("pads", eoe | I_PORT_LATCH, pads);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge I_MCLK);
    num_errors++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    repeat (5) @(posedge I_MCLK);
    I_RST_N <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      if (k == 4) rd(idx[k], 32'h0, pdc_pkg::RESP_SLVERR);
      else rd(idx[k], 32'hFF, pdc_pkg::RESP_OKAY);
    end
    chk("oe_n reset", {72{1'b1}}, O_PIN_OE_N);
    $display("test reset done");
    sweep(pdc_pkg::WMASK_64, 1'b0);
    $display("test 64-pin done");
    // The strap needs three enabled edges through its synchroniser.
    @(posedge I_MCLK);
    I_PKG80 <= 1'b1;
    repeat (5) @(posedge I_MCLK);
    sweep(pdc_pkg::WMASK_80, 1'b1);
    $display("test 80-pin done");
    rd(20'h00010, 32'h0, pdc_pkg::RESP_SLVERR);
    wr(20'h00010, 8'h00, pdc_pkg::RESP_SLVERR);
    $display("test unmapped done");
    wr(pdc_pkg::IDX_CTRL, 8'h01, pdc_pkg::RESP_OKAY);
    repeat (2) @(posedge I_MCLK);
    chk("bit0 out", 1, O_PORT13_BIT0_OUT);
    wr(pdc_pkg::IDX_CTRL, 8'h00, pdc_pkg::RESP_OKAY);
    repeat (2) @(posedge I_MCLK);
    chk("bit0 out", 0, O_PORT13_BIT0_OUT);
    $display("test output pin done");
    // Each edge code sees one rising and one falling pin edge.
    for (int c = 0; c < 5; c++) begin
      wr(pdc_pkg::IDX_CTRL, (c == 4) ? 8'h08 : 8'((c << 2) | 2), pdc_pkg::RESP_OKAY);
      // Clear any edge left over from the previous code before this one starts.
      wr(pdc_pkg::IDX_STAT, 8'h04, pdc_pkg::RESP_OKAY);
      repeat (8) @(posedge I_MCLK);
      pulses = 0;
      pin_lvl <= 1'b1;
      repeat (8) @(posedge I_MCLK);
      // Only rising and both codes in control mode record the rising edge.
      rd(pdc_pkg::IDX_STAT, {29'h0, (c == 1 || c == 2), 2'h3}, pdc_pkg::RESP_OKAY);
      wr(pdc_pkg::IDX_STAT, 8'h04, pdc_pkg::RESP_OKAY);
      @(posedge I_MCLK);
      pin_lvl <= 1'b0;
      repeat (8) @(posedge I_MCLK);
      // Only falling and both codes in control mode record the falling edge.
      rd(pdc_pkg::IDX_STAT, {29'h0, (c == 0 || c == 2), 2'h2}, pdc_pkg::RESP_OKAY);
      chk("irq pulses", (c == 4) ? 0 : exp_irq[c], pulses);
    end
    $display("test interrupt done");
    // A low clock enable must hold back a pin edge until it rises again.
    wr(pdc_pkg::IDX_CTRL, 8'h06, pdc_pkg::RESP_OKAY);
    repeat (2) @(posedge I_MCLK);
    pulses = 0;
    I_CE <= 1'b0;
    pin_lvl <= 1'b1;
    repeat (8) @(posedge I_MCLK);
    chk("irq frozen", 0, pulses);
    I_CE <= 1'b1;
    repeat (8) @(posedge I_MCLK);
    chk("irq after enable", 1, pulses);
    $display("test clock enable done");
    wrap_up();
  end
endmodule

`default_nettype wire
